// File: wake_pin_detector.sv
// Wake pin detector: filter, wake/interrupt, bias control and registers
//
// Operation
// - Both pin edges are wake events
// - Enabled edge: interrupt in Normal/Stop, wake Sleep
// - Any edge in Fail-Safe enters Restart
// - Pin level picks buck modulation in Stop
// - Modulation select uses unfiltered pin level
// - Static or cyclic sensing selectable
// - Edge accepted after 16 us filter
// - Enable bit gates wake and interrupt
// - Pin level readable in Normal/Stop
// - Pin wake sets wake-source flag
// - Bias code: none, pull-down, pull-up
// - Both bias bits: automatic follow switching
// - Edge and wake interrupts only when enabled as wake source; restart is not gated
// - Level status never raises interrupts
// - Wake flag sticky until software clears
//
// Register map on the plain register port
//   0 control: bit0 wake enable, bit1 cyclic sensing,
//     bit2 pin level picks buck modulation in Stop
//   1 bias select: 00 none, 01 pull-down, 10 pull-up, 11 automatic
//   2 wake status: bit0 pin wake-source flag, write one to clear
//   3 level status: bit0 synchronised pin, zero outside Normal/Stop
//   4 interrupt status: bit2 restart, bit1 wake, bit0 edge; read only
//   5 interrupt clear: write one to clear a status bit, reads zero
//   6 interrupt enable: same layout as the status register
//   7 mode readback: the device mode as this block sees it
//
// Limitations: a cyclic window shorter than the filter time never
// accepts an edge, because closing the window restarts the count.
// Pin pulses shorter than the filter time are lost for good; the
// level status bit may still show them, since it skips the filter.

`timescale 1ns/1ns
`include "wpd_consts.svh"
module wake_pin_detector #(
  parameter int FILTER_CYCLES = `WPD_FILTER_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic      [7:0]            regRdData,
  input  wire logic                  wakePin,
  input  wire wpd_pkg::wpd_mode_t    deviceMode,
  input  wire logic                  cyclicWindow,
  output logic                       pullUpEn,
  output logic                       pullDownEn,
  output logic                       pulseFreqModSel,
  output logic                       wakeRequest,
  output logic                       restartRequest,
  output logic                       irqOut
);
  import wpd_pkg::*;

  // Pin path
  logic                      pinSync;
  logic                      pinFilt;
  logic                      filtEdge;
  logic                      sampleEn;
  logic                      modSelNext;
  logic                      levelStatus;

  // Software-visible state
  logic [7:0]                ctrlReg;
  logic [1:0]                biasReg;
  logic                      wakeFlagReg;
  logic [`WPD_IRQ_WIDTH-1:0] irqStatReg;
  logic [`WPD_IRQ_WIDTH-1:0] irqEnReg;
  logic [7:0]                rdDataNext;

  // Event decode and interrupt bookkeeping
  logic [`WPD_IRQ_WIDTH-1:0] irqEvt;
  logic [`WPD_IRQ_WIDTH-1:0] irqClrMask;
  logic [`WPD_IRQ_WIDTH-1:0] irqStatNext;
  logic                      wakeEn;
  logic                      activeMode;
  logic                      edgeIrq;
  logic                      edgeWake;
  logic                      edgeRestart;

  // Bias decode
  logic                      biasUpNext;
  logic                      biasDownNext;

  // Write strobes, one per writable register
  logic                      wrCtrl;
  logic                      wrBias;
  logic                      wrWakeStat;
  logic                      wrIrqClr;
  logic                      wrIrqEn;

  // Synchronise the pin before any use, so the filter, level status
  // and modulation select all see one and the same value
  wpd_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (wakePin),
    .syncOut (pinSync)
  );

  // Cyclic sensing only samples inside the active window
  assign sampleEn = !ctrlReg[`WPD_CTRL_CYCLIC] || cyclicWindow;

  // Glitch filter qualifies both edge directions
  // Runs on sys_clk; FILTER_CYCLES sets the filter time at this rate
  wpd_filter #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_filter (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .levelIn   (pinSync),
    .sampleEn  (sampleEn),
    .levelOut  (pinFilt),
    .edgePulse (filtEdge)
  );

  // Event decode by mode
  // Sleep wake and Normal/Stop interrupt share the one enable bit
  assign wakeEn      = ctrlReg[`WPD_CTRL_WAKE_EN];
  assign activeMode  = (deviceMode == WPD_MODE_NORMAL) ||
                       (deviceMode == WPD_MODE_STOP);
  assign edgeIrq     = filtEdge && wakeEn && activeMode;
  assign edgeWake    = filtEdge && wakeEn &&
                       (deviceMode == WPD_MODE_SLEEP);
  // Fail-Safe exit does not depend on the enable bit
  assign edgeRestart = filtEdge &&
                       (deviceMode == WPD_MODE_FAILSAFE);

  // Level status is not an interrupt source at all
  assign irqEvt = {edgeRestart, edgeWake, edgeIrq};

  // Write decode
  assign wrCtrl   = regWrStb && (regAddr == `WPD_ADDR_CTRL);
  assign wrBias   = regWrStb && (regAddr == `WPD_ADDR_BIAS);
  assign wrWakeStat = regWrStb && (regAddr == `WPD_ADDR_WAKE_STAT);
  assign wrIrqClr = regWrStb && (regAddr == `WPD_ADDR_IRQ_CLR);
  assign wrIrqEn  = regWrStb && (regAddr == `WPD_ADDR_IRQ_EN);

  // Control register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrlReg <= `WPD_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlReg <= {5'h00, regWrData[2:0]};
    end
  end

  // Bias select register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      biasReg <= `WPD_BIAS_RESET;
    end else if (wrBias) begin
      biasReg <= regWrData[1:0];
    end
  end

  // Pin wake-source flag, set by any pin edge that raises an edge, wake or restart event;
  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeFlagReg <= 1'b0;
    end else if (edgeWake || edgeRestart || edgeIrq) begin
      wakeFlagReg <= 1'b1;
    end else if (wrWakeStat && regWrData[0]) begin
      wakeFlagReg <= 1'b0;
    end
  end

  // Clear mask from the write-only clear register
  assign irqClrMask  = wrIrqClr ? regWrData[`WPD_IRQ_WIDTH-1:0] : '0;
  // A new event wins over a clear in the same cycle
  assign irqStatNext = (irqStatReg & ~irqClrMask) | irqEvt;

  // Sticky interrupt status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStatReg <= '0;
    end else begin
      irqStatReg <= irqStatNext;
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqEnReg <= '0;
    end else if (wrIrqEn) begin
      irqEnReg <= regWrData[`WPD_IRQ_WIDTH-1:0];
    end
  end

  // Level interrupt output from registers
  // Registered so the output never glitches on a decode hazard
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(irqStatReg & irqEnReg);
    end
  end

  // One-cycle wake and restart requests to the mode controller;
  // the controller must latch them, they are not held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeRequest    <= 1'b0;
      restartRequest <= 1'b0;
    end else begin
      wakeRequest    <= edgeWake;
      restartRequest <= edgeRestart;
    end
  end

  // Bias code decode; auto mode follows the filtered level so a
  // glitch never flips the current source
  always_comb begin
    biasUpNext   = 1'b0;
    biasDownNext = 1'b0;
    case (wpd_bias_t'(biasReg))
      WPD_BIAS_NONE: begin
        biasUpNext   = 1'b0;
        biasDownNext = 1'b0;
      end
      WPD_BIAS_DOWN: begin
        biasUpNext   = 1'b0;
        biasDownNext = 1'b1;
      end
      WPD_BIAS_UP: begin
        biasUpNext   = 1'b1;
        biasDownNext = 1'b0;
      end
      WPD_BIAS_AUTO: begin
        biasUpNext   = pinFilt;
        biasDownNext = !pinFilt;
      end
      default: begin
        biasUpNext   = 1'b0;
        biasDownNext = 1'b0;
      end
    endcase
  end

  // Bias current enables from flip-flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pullUpEn   <= 1'b0;
      pullDownEn <= 1'b0;
    end else begin
      pullUpEn   <= biasUpNext;
      pullDownEn <= biasDownNext;
    end
  end

  // Modulation select uses the raw synced level: the host drives a
  // defined level here, so waiting out the filter only adds delay
  assign modSelNext = ctrlReg[`WPD_CTRL_PIN_MOD] &&
                      (deviceMode == WPD_MODE_STOP) &&
                      !pinSync;

  // Registered so the buck converter sees a clean level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulseFreqModSel <= 1'b0;
    end else begin
      pulseFreqModSel <= modSelNext;
    end
  end

  // Level status reads zero outside Normal and Stop
  assign levelStatus = pinSync && activeMode;

  // Read multiplexer; write-only and unmapped indices read zero
  always_comb begin
    rdDataNext = 8'h00;
    if (regRdStb) begin
      case (regAddr)
        `WPD_ADDR_CTRL:      rdDataNext = ctrlReg;
        `WPD_ADDR_BIAS:      rdDataNext = {6'h00, biasReg};
        `WPD_ADDR_WAKE_STAT: rdDataNext = {7'h00, wakeFlagReg};
        `WPD_ADDR_LVL_STAT:  rdDataNext = {7'h00, levelStatus};
        `WPD_ADDR_IRQ_STAT:  rdDataNext = {5'h00, irqStatReg};
        `WPD_ADDR_IRQ_EN:    rdDataNext = {5'h00, irqEnReg};
        `WPD_ADDR_MODE:      rdDataNext = {5'h00, deviceMode};
        default:             rdDataNext = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rdDataNext;
    end
  end

endmodule

// File: wake_pin_detector_tb.sv
// Self-checking bench for the wake pin detector
`timescale 1ns/1ns
module wake_pin_detector_tb;
  import wpd_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWrStb = 1'b0;
  logic       regRdStb = 1'b0;
  logic       pinLevel = 1'b0;
  logic       cyclicWindow = 1'b0;
  wpd_mode_t  deviceMode = WPD_MODE_NORMAL;
  logic [7:0] regRdData;
  logic       wakePin, pullUpEn, pullDownEn, pulseFreqModSel;
  logic       wakeRequest, restartRequest, irqOut;
  logic [31:0] rng = 32'h0000fd72;
  int         error_cnt = 0;
  int         checked = 0;
  wire [2:0]  watch = {restartRequest, wakeRequest, irqOut};

  always #5 sys_clk = ~sys_clk;

  wpd_wake_source wpd_wake_source_i (.sys_clk(sys_clk),
    .lineLevel(pinLevel), .wakePin(wakePin));
  // Short filter keeps the run brief
  wake_pin_detector #(.FILTER_CYCLES(8)) wake_pin_detector_i (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .wakePin(wakePin), .deviceMode(deviceMode),
    .cyclicWindow(cyclicWindow), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .pulseFreqModSel(pulseFreqModSel),
    .wakeRequest(wakeRequest), .restartRequest(restartRequest),
    .irqOut(irqOut));

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Each bus task opens on a fresh edge so no strobe is set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    check("regRdData", regRdData, e);
  endtask

  task automatic set_pin(input logic v);
    @(posedge sys_clk);
    pinLevel <= v;
  endtask

  // Bounded wait for one event line; a missed event ends the run
  task automatic wait_bit(input int i, input logic e);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 40 && !hit; n++) begin
      @(posedge sys_clk);
      #1;
      hit = (watch[i] === 1'b1);
    end
    check("event", {7'h0, hit}, {7'h0, e});
    if (e && !hit) finish_test();
  endtask

  initial begin
    logic [31:0] rnd;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rnd = xorshift();
    wr(4'h9, rnd[7:0]);
    rd(4'h9, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(4'h1, 8'(b));
      repeat (2) @(posedge sys_clk);
      #1;
      check("pullUp", {7'h0, pullUpEn}, {7'h0, b == 2});
      check("pullDown", {7'h0, pullDownEn}, {7'h0, b[0]});
    end
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h01);
    // Random glitch, always shorter than the filter
    set_pin(1'b1);
    repeat (1 + rnd[2:0] % 5) @(posedge sys_clk);
    set_pin(1'b0);
    wait_bit(0, 1'b0);
    for (int v = 1; v >= 0; v--) begin
      set_pin(v[0]);
      wait_bit(0, 1'b1);
      rd(4'h4, 8'h01);
      rd(4'h3, {7'h0, v[0]});
      check("pullUp", {7'h0, pullUpEn}, {7'h0, v[0]});
      wr(4'h5, 8'h07);
      rd(4'h2, 8'h01);
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h00);
      check("irqOut", {7'h0, irqOut}, 8'h00);
    end
    wr(4'h0, 8'h00);
    set_pin(1'b1);
    wait_bit(0, 1'b0);
    rd(4'h2, 8'h00);
    @(posedge sys_clk);
    deviceMode <= WPD_MODE_SLEEP;
    wr(4'h0, 8'h01);
    set_pin(1'b0);
    wait_bit(1, 1'b1);
    rd(4'h4, 8'h02);
    rd(4'h2, 8'h01);
    rd(4'h3, 8'h00);
    @(posedge sys_clk);
    deviceMode <= WPD_MODE_FAILSAFE;
    wr(4'h0, 8'h00);
    set_pin(1'b1);
    wait_bit(2, 1'b1);
    rd(4'h3, 8'h00);
    wr(4'h5, 8'h07);
    wr(4'h2, 8'h01);
    deviceMode <= WPD_MODE_STOP;
    wr(4'h0, 8'h04);
    set_pin(1'b0);
    repeat (5) @(posedge sys_clk);
    #1;
    check("modSel", {7'h0, pulseFreqModSel}, 8'h01);
    set_pin(1'b1);
    repeat (5) @(posedge sys_clk);
    #1;
    check("modSel", {7'h0, pulseFreqModSel}, 8'h00);
    wr(4'h0, 8'h03);
    set_pin(1'b0);
    wait_bit(0, 1'b0);
    @(posedge sys_clk);
    cyclicWindow <= 1'b1;
    wait_bit(0, 1'b1);
    rd(4'h4, 8'h01);
    finish_test();
  end
endmodule

// File: wpd_consts.svh
// Offsets, field positions, reset values and timing counts for the wake pin block
`ifndef WPD_CONSTS_SVH
`define WPD_CONSTS_SVH

// Register indices on the plain register port
`define WPD_ADDR_CTRL        4'h0
`define WPD_ADDR_BIAS        4'h1
`define WPD_ADDR_WAKE_STAT   4'h2
`define WPD_ADDR_LVL_STAT    4'h3
`define WPD_ADDR_IRQ_STAT    4'h4
`define WPD_ADDR_IRQ_CLR     4'h5
`define WPD_ADDR_IRQ_EN      4'h6
`define WPD_ADDR_MODE        4'h7

// Control register fields
`define WPD_CTRL_WAKE_EN     0
`define WPD_CTRL_CYCLIC      1
`define WPD_CTRL_PIN_MOD     2
`define WPD_CTRL_RESET       8'h00

// Bias register reset value (no current source)
`define WPD_BIAS_RESET       2'h0

// Interrupt bit layout
`define WPD_IRQ_WAKE_EDGE    0
`define WPD_IRQ_WAKE_UP      1
`define WPD_IRQ_RESTART      2
`define WPD_IRQ_WIDTH        3

// Wake filter time in ns and its cycle count at 100 MHz
`define WPD_FILTER_TIME_NS   16000
`define WPD_CLK_PERIOD_NS    10
`define WPD_FILTER_CYCLES    (`WPD_FILTER_TIME_NS / `WPD_CLK_PERIOD_NS)

`endif

// File: wpd_filter.sv
// Glitch filter: accepts a new level after it holds for FILTER_CYCLES
`timescale 1ns/1ns
module wpd_filter #(
  parameter int FILTER_CYCLES = 1600
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic levelIn,
  input  wire logic sampleEn,
  output logic      levelOut,
  output logic      edgePulse
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic [CW-1:0] countReg;

  // Count while input differs; any reversal restarts the count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      countReg  <= '0;
      levelOut  <= 1'b0;
      edgePulse <= 1'b0;
    end else begin
      edgePulse <= 1'b0;
      if (!sampleEn || levelIn == levelOut) begin
        countReg <= '0;
      end else if (countReg == CW'(FILTER_CYCLES - 1)) begin
        countReg  <= '0;
        levelOut  <= levelIn;
        edgePulse <= 1'b1;
      end else begin
        countReg <= countReg + 1'b1;
      end
    end
  end

endmodule

// File: wpd_pkg.sv
// Types shared by the wake pin block
package wpd_pkg;

  // Device operating modes as seen by the wake pin logic
  typedef enum logic [2:0] {
    WPD_MODE_NORMAL   = 3'h0,
    WPD_MODE_STOP     = 3'h1,
    WPD_MODE_SLEEP    = 3'h2,
    WPD_MODE_FAILSAFE = 3'h3,
    WPD_MODE_RESTART  = 3'h4
  } wpd_mode_t;

  // Pull current source selection
  typedef enum logic [1:0] {
    WPD_BIAS_NONE = 2'h0,
    WPD_BIAS_DOWN = 2'h1,
    WPD_BIAS_UP   = 2'h2,
    WPD_BIAS_AUTO = 2'h3
  } wpd_bias_t;

endpackage

// File: wpd_props.sv
// Port checker for the wake pin detector
`timescale 1ns/1ns
module wpd_props #(
  parameter int FILTER_CYCLES = 8
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic [3:0]         regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWrStb,
  input wire logic               regRdStb,
  input wire logic [7:0]         regRdData,
  input wire logic               wakePin,
  input wire wpd_pkg::wpd_mode_t deviceMode,
  input wire logic               cyclicWindow,
  input wire logic               pullUpEn,
  input wire logic               pullDownEn,
  input wire logic               pulseFreqModSel,
  input wire logic               wakeRequest,
  input wire logic               restartRequest,
  input wire logic               irqOut
);
  import wpd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic pinReg;
  int   stableCnt;
  // Cycles since the pin last moved; saturates so it never wraps
  always_ff @(posedge sys_clk) begin
    pinReg <= wakePin;
    if (rst || wakePin != pinReg) begin
      stableCnt <= 0;
    end else if (stableCnt < 1000) begin
      stableCnt <= stableCnt + 1;
    end
  end
  a_wake_one_pulse: assert property (
    wakeRequest |=> !wakeRequest) else $error("wake pulse too long");
  a_wake_sleep_only: assert property (
    wakeRequest |-> $past(deviceMode) == WPD_MODE_SLEEP)
    else $error("wake outside sleep");
  a_restart_one_pulse: assert property (
    restartRequest |=> !restartRequest) else $error("restart too long");
  a_restart_fs_only: assert property (
    restartRequest |-> $past(deviceMode) == WPD_MODE_FAILSAFE)
    else $error("restart outside fail-safe");
  a_req_exclusive: assert property (
    !(wakeRequest && restartRequest)) else $error("both requests");
  a_modsel_stop_only: assert property (
    pulseFreqModSel |-> $past(deviceMode) == WPD_MODE_STOP)
    else $error("modulation select outside stop");
  a_bias_exclusive: assert property (
    !(pullUpEn && pullDownEn)) else $error("both bias currents");
  a_req_filtered: assert property (
    (wakeRequest || restartRequest) |-> stableCnt >= FILTER_CYCLES + 2)
    else $error("request before filter time");
  a_rd_idle_zero: assert property (
    !$past(regRdStb) |-> regRdData == 8'h00) else $error("stray data");
endmodule

bind wake_pin_detector wpd_props #(.FILTER_CYCLES(FILTER_CYCLES)) wpd_props_i (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .wakePin(wakePin), .deviceMode(deviceMode), .cyclicWindow(cyclicWindow),
  .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
  .pulseFreqModSel(pulseFreqModSel), .wakeRequest(wakeRequest),
  .restartRequest(restartRequest), .irqOut(irqOut));

// File: wpd_sync.sv
// Two-stage synchroniser for the asynchronous wake pin
`timescale 1ns/1ns
module wpd_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1Reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1Reg <= 1'b0;
      syncOut   <= 1'b0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

// File: wpd_wake_source.sv
// Model of the switch line driving the wake pin
`timescale 1ns/1ns
module wpd_wake_source (
  input  wire logic sys_clk,
  input  wire logic lineLevel,
  output logic      wakePin
);
  // Actively driven line, so the pin never floats
  initial wakePin = 1'b0;
  always @(posedge sys_clk) begin
    wakePin <= lineLevel;
  end
endmodule
